// >>> src/fp_exception_classifier.sv
`timescale 1ns/10ps
`default_nettype none
`include "fp_status_cfg.svh"

// Combinational screen that turns raw operation conditions into the five
// exception bits, before trap enables are applied.
module fp_exception_classifier (
  input wire logic [3:0] op_class_in,
  input wire logic [1:0] src_prec_in,
  input wire logic [1:0] dst_prec_in,
  input wire logic snan_operand_in,
  input wire logic nan_operand_in,
  input wire logic invalid_operand_in,
  input wire logic int_convert_fail_in,
  input wire logic div_zero_in,
  input wire logic overflow_in,
  input wire logic tiny_in,
  input wire logic accuracy_loss_in,
  input wire logic inexact_in,
  input wire logic snan_convert_fault_in,
  input wire logic underflow_trap_in,
  output logic [4:0] raised_out
);

  logic same_prec;
  logic snan_exempt;
  logic snan_fault;
  logic underflow;

  // Decides which exceptions the operation raises.
  always_comb
  begin
    same_prec = (src_prec_in == dst_prec_in);
    // Loads and multiple transfers always pass signalling NaNs; moves, negated moves, abs and stores pass them at the same precision.
    case (op_class_in)
      4'h1, 4'h2, 4'h3: snan_exempt = 1'b1;
      4'h4, 4'h5, 4'h6, 4'h7: snan_exempt = same_prec;
      4'h8:
      begin
        // Extended is an internal format unless the control bit says not.
        if (snan_convert_fault_in)
        begin
          snan_exempt = same_prec;
        end
        else
        begin
          snan_exempt = (src_prec_in == 2'h2) || (dst_prec_in == 2'h2) || same_prec;
        end
      end
      default: snan_exempt = 1'b0;
    endcase
    snan_fault = snan_operand_in && !snan_exempt;
    // Underflow depends on the trap enable.
    if (underflow_trap_in)
    begin
      underflow = tiny_in;
    end
    else
    begin
      underflow = tiny_in && accuracy_loss_in;
    end
    raised_out = 5'h00;
    raised_out[`FPS_EXC_INVALID] = invalid_operand_in || snan_fault || int_convert_fail_in
      || (((op_class_in == 4'h9) || (op_class_in == 4'hA)) && nan_operand_in);
    raised_out[`FPS_EXC_DIVZERO] = div_zero_in;
    raised_out[`FPS_EXC_OVERFLOW] = overflow_in;
    raised_out[`FPS_EXC_UNDERFLOW] = underflow;
    raised_out[`FPS_EXC_INEXACT] = inexact_in || overflow_in || underflow;
  end

endmodule // fp_exception_classifier

`default_nettype wire

// >>> src/fp_status_cfg.svh
`ifndef FP_STATUS_CFG_SVH
`define FP_STATUS_CFG_SVH

// Status word byte fields.
`define FPS_IDENT_MSB 31
`define FPS_IDENT_LSB 24
`define FPS_TRAP_LSB 16
`define FPS_CTRL_LSB 8
`define FPS_FLAG_LSB 0

// Exception bit order within the trap-enable and flag fields.
`define FPS_EXC_INVALID 0
`define FPS_EXC_DIVZERO 1
`define FPS_EXC_OVERFLOW 2
`define FPS_EXC_UNDERFLOW 3
`define FPS_EXC_INEXACT 4
`define FPS_EXC_COUNT 5

// Control bit positions within the status word.
`define FPS_FLUSH_DENORMALS_BIT 8
`define FPS_SNAN_CONVERT_FAULT_BIT 9
`define FPS_SYNC_OPERATION_BIT 10
`define FPS_EXPANDED_DECIMAL_BIT 11
`define FPS_ALT_CARRY_COMPARE_BIT 12
`define FPS_CTRL_COUNT 5

// Identity byte; the value is arbitrary.
`define FPS_IDENTITY_VALUE 8'hA5

`endif

// >>> src/fp_status_exception_unit.sv
`timescale 1ns/10ps
`default_nettype none
`include "fp_status_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
// Operation
// - Status word holds four bytes.
// - Reset leaves status word contents untouched.
// - Identity byte read-only, bit 31 marks hardware.
// - Trap enables in bits 16 to 20.
// - Enabled exception traps instead of flagging.
// - Untrapped exceptions set flags bits 0-4.
// - Flags sticky, cleared only by status write.
// - Bit 8 flushes denormals to zero.
// - Bit 9 widens signalling NaN conversion faults.
// - Bit 10 forces synchronous precise operation.
// - Bit 11 selects expanded packed decimal.
// - Bit 12 selects alternative compare carry.
// - Invalid operand raises invalid, quiet NaN.
// - Listed arithmetic cases signal invalid operation.
// - Signalling NaN invalid except listed moves.
// - Impossible integer conversion signals invalid.
// - Faulting compares signal invalid on NaN.
// - Finite nonzero over zero signals divide.
// - Overflow on rounded unbounded magnitude.
// - Underflow condition depends on trap enable.
// - Inexact rules; overflow/underflow traps take priority.
module fp_status_exception_unit (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic status_write_instr_in,
  input wire logic [31:0] status_write_data_in,
  input wire logic status_read_instr_in,
  input wire logic op_valid_in,
  input wire logic [3:0] op_class_in,
  input wire logic [1:0] src_prec_in,
  input wire logic [1:0] dst_prec_in,
  input wire logic snan_operand_in,
  input wire logic nan_operand_in,
  input wire logic invalid_operand_in,
  input wire logic int_convert_fail_in,
  input wire logic div_zero_in,
  input wire logic overflow_in,
  input wire logic tiny_in,
  input wire logic accuracy_loss_in,
  input wire logic inexact_in,
  output logic [31:0] fp_status_word_out,
  output logic status_read_valid_out,
  output logic trap_out,
  output logic [4:0] trap_cause_out,
  output logic flush_denormals_out,
  output logic snan_convert_fault_out,
  output logic sync_operation_out,
  output logic expanded_decimal_out,
  output logic alt_carry_compare_out,
  output logic quiet_nan_result_out,
  output logic busy_out
);

  //////////////////////////////////////////////////////////////////////////////
  // Storage.

  // Trap-enable, control and flag fields; deliberately without reset.
  logic [4:0] trap_enable_q;
  logic [4:0] trap_enable_d;
  logic [4:0] control_q;
  logic [4:0] control_d;
  logic [4:0] flags_q;
  logic [4:0] flags_d;
  // Output pipeline registers, which do reset.
  logic [31:0] word_q;
  logic [31:0] word_d;
  logic read_valid_q;
  logic read_valid_d;
  logic trap_q;
  logic trap_d;
  logic [4:0] cause_q;
  logic [4:0] cause_d;
  logic qnan_q;
  logic qnan_d;
  fp_status_pkg::unit_state_type state_q;
  fp_status_pkg::unit_state_type state_d;
  // Exceptions raised by the current operation.
  logic [4:0] raised;
  logic [4:0] trapped;
  logic [4:0] untrapped;

  //////////////////////////////////////////////////////////////////////////////
  // Exception screening.

  // Classifier turns operation conditions into exception bits.
  fp_exception_classifier classify (
    .op_class_in(op_class_in),
    .src_prec_in(src_prec_in),
    .dst_prec_in(dst_prec_in),
    .snan_operand_in(snan_operand_in),
    .nan_operand_in(nan_operand_in),
    .invalid_operand_in(invalid_operand_in),
    .int_convert_fail_in(int_convert_fail_in),
    .div_zero_in(div_zero_in),
    .overflow_in(overflow_in),
    .tiny_in(tiny_in),
    .accuracy_loss_in(accuracy_loss_in),
    .inexact_in(inexact_in),
    .snan_convert_fault_in(control_q[`FPS_SNAN_CONVERT_FAULT_BIT - `FPS_CTRL_LSB]),
    .underflow_trap_in(trap_enable_q[`FPS_EXC_UNDERFLOW]),
    .raised_out(raised)
  );

  // Splits raised exceptions into trapped and flagged sets.
  always_comb
  begin
    trapped = 5'h00;
    untrapped = 5'h00;
    if (op_valid_in)
    begin
      trapped = raised & trap_enable_q;
      untrapped = raised & ~trap_enable_q;
      // An overflow or underflow trap takes priority over the inexact trap.
      if (trapped[`FPS_EXC_OVERFLOW] || trapped[`FPS_EXC_UNDERFLOW])
      begin
        trapped[`FPS_EXC_INEXACT] = 1'b0;
        // A trapped overflow or underflow does not count as inexact; only a truly inexact rounding still flags.
        untrapped[`FPS_EXC_INEXACT] = untrapped[`FPS_EXC_INEXACT] && inexact_in;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Status word fields.

  // Next values of the status word fields.
  always_comb
  begin
    trap_enable_d = trap_enable_q;
    control_d = control_q;
    flags_d = flags_q | untrapped;
    if (status_write_instr_in)
    begin
      // The write replaces all writable fields; identity byte stays fixed.
      trap_enable_d = status_write_data_in[`FPS_TRAP_LSB +: 5];
      control_d = status_write_data_in[`FPS_CTRL_LSB +: 5];
      // A flag raised in the same cycle survives the write.
      flags_d = status_write_data_in[`FPS_FLAG_LSB +: 5] | untrapped;
    end
  end

  // Fields hold their contents through reset.
  always_ff @(posedge clk_in)
  begin
    trap_enable_q <= trap_enable_d;
    control_q <= control_d;
    flags_q <= flags_d;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Reporting.

  // Builds the read image, trap report and the busy handshake.
  always_comb
  begin
    word_d = 32'h0000_0000;
    word_d[`FPS_IDENT_MSB:`FPS_IDENT_LSB] = `FPS_IDENTITY_VALUE | 8'h80;
    word_d[`FPS_TRAP_LSB +: 5] = trap_enable_q;
    word_d[`FPS_CTRL_LSB +: 5] = control_q;
    word_d[`FPS_FLAG_LSB +: 5] = flags_q;
    read_valid_d = status_read_instr_in;
    trap_d = |trapped;
    cause_d = trapped;
    qnan_d = untrapped[`FPS_EXC_INVALID];
    state_d = state_q;
    case (state_q)
      fp_status_pkg::st_idle_type:
      begin
        // Synchronous mode holds the core for one reporting cycle.
        if (op_valid_in && control_q[`FPS_SYNC_OPERATION_BIT - `FPS_CTRL_LSB])
        begin
          state_d = fp_status_pkg::st_report_type;
        end
      end
      fp_status_pkg::st_report_type:
      begin
        state_d = fp_status_pkg::st_idle_type;
      end
      default:
      begin
        state_d = fp_status_pkg::st_idle_type;
      end
    endcase
  end

  // Output registers, cleared by reset.
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      word_q <= 32'h0000_0000;
      read_valid_q <= 1'b0;
      trap_q <= 1'b0;
      cause_q <= 5'h00;
      qnan_q <= 1'b0;
      state_q <= fp_status_pkg::st_idle_type;
    end
    else
    begin
      word_q <= word_d;
      read_valid_q <= read_valid_d;
      trap_q <= trap_d;
      cause_q <= cause_d;
      qnan_q <= qnan_d;
      state_q <= state_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign fp_status_word_out = word_q;
  assign status_read_valid_out = read_valid_q;
  assign trap_out = trap_q;
  assign trap_cause_out = cause_q;
  assign quiet_nan_result_out = qnan_q;
  assign busy_out = state_q[1];
  // Control bits come straight from their storage flops.
  assign flush_denormals_out = control_q[`FPS_FLUSH_DENORMALS_BIT - `FPS_CTRL_LSB];
  assign snan_convert_fault_out = control_q[`FPS_SNAN_CONVERT_FAULT_BIT - `FPS_CTRL_LSB];
  assign sync_operation_out = control_q[`FPS_SYNC_OPERATION_BIT - `FPS_CTRL_LSB];
  assign expanded_decimal_out = control_q[`FPS_EXPANDED_DECIMAL_BIT - `FPS_CTRL_LSB];
  assign alt_carry_compare_out = control_q[`FPS_ALT_CARRY_COMPARE_BIT - `FPS_CTRL_LSB];

endmodule // fp_status_exception_unit

`default_nettype wire

// >>> src/fp_status_pkg.sv
package fp_status_pkg;

  // Classes of instruction that matter for exception screening.
  typedef enum logic [3:0] {
    op_arith_type = 4'h0,
    op_load_type = 4'h1,
    op_load_multiple_type = 4'h2,
    op_store_multiple_type = 4'h3,
    op_move_type = 4'h4,
    op_move_negated_type = 4'h5,
    op_abs_type = 4'h6,
    op_store_type = 4'h7,
    op_convert_type = 4'h8,
    op_compare_fault_type = 4'h9,
    op_neg_compare_fault_type = 4'hA,
    op_compare_type = 4'hB,
    op_to_integer_type = 4'hC,
    op_other_type = 4'hF
  } op_class_type;

  // Precisions for conversion screening.
  typedef enum logic [1:0] {
    prec_single_type = 2'h0,
    prec_double_type = 2'h1,
    prec_extended_type = 2'h2
  } precision_type;

  // Unit state.
  typedef enum logic [1:0] {
    st_idle_type = 2'b01,
    st_report_type = 2'b10
  } unit_state_type;

endpackage

// >>> verification/fp_status_exception_unit_properties.sv
`timescale 1ns/10ps
`default_nettype none
`include "fp_status_cfg.svh"

// Checker for the status word, trap and flag outputs.
module fp_status_exception_unit_properties (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic status_write_instr_in,
  input wire logic [31:0] status_write_data_in,
  input wire logic status_read_instr_in,
  input wire logic op_valid_in,
  input wire logic [3:0] op_class_in,
  input wire logic snan_operand_in,
  input wire logic nan_operand_in,
  input wire logic invalid_operand_in,
  input wire logic int_convert_fail_in,
  input wire logic div_zero_in,
  input wire logic overflow_in,
  input wire logic tiny_in,
  input wire logic accuracy_loss_in,
  input wire logic inexact_in,
  input wire logic [31:0] fp_status_word_out,
  input wire logic status_read_valid_out,
  input wire logic trap_out,
  input wire logic [4:0] trap_cause_out,
  input wire logic flush_denormals_out,
  input wire logic snan_convert_fault_out,
  input wire logic sync_operation_out,
  input wire logic expanded_decimal_out,
  input wire logic alt_carry_compare_out,
  input wire logic quiet_nan_result_out,
  input wire logic busy_out
);
  wire logic [8:0] conds = {snan_operand_in, nan_operand_in, invalid_operand_in, int_convert_fail_in, div_zero_in,
    overflow_in, tiny_in, accuracy_loss_in, inexact_in};
  wire logic [4:0] flags = fp_status_word_out[4:0];
  wire logic [4:0] ctrl = {alt_carry_compare_out, expanded_decimal_out, sync_operation_out, snan_convert_fault_out,
    flush_denormals_out};
  wire logic arith = op_valid_in && (op_class_in == 4'h0);
  // The fields are never reset, so the word is trusted only after a write has landed.
  logic wrote_q = 1'b0;
  logic settled_q;
  always @(posedge clk_in)
    if (status_write_instr_in)
      wrote_q <= 1'b1;
  // High when the word image already carries the current enables.
  always_ff @(posedge clk_in or posedge reset_in)
    if (reset_in)
      settled_q <= 1'b0;
    else
      settled_q <= wrote_q && !status_write_instr_in;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);
  // An untrapped divide by zero gives no trap, then shows in the word.
  sequence s_no_trap_then_flag;
    !trap_out ##1 flags[1];
  endsequence
  a_ident_fixed: assert property (!$past(reset_in) |-> fp_status_word_out[31:24] == (`FPS_IDENTITY_VALUE | 8'h80))
    else $error("identity byte wrong");
  a_reserved_zero: assert property ((fp_status_word_out & 32'h00E0E0E0) == 32'h00000000)
    else $error("reserved bits set");
  a_dz_trapped: assert property (settled_q && arith && conds == 9'h010 && fp_status_word_out[17]
    |=> trap_out && trap_cause_out == 5'h02) else $error("enabled divide by zero did not trap");
  a_dz_flagged: assert property (settled_q && arith && conds == 9'h010 && !fp_status_word_out[17]
    |=> s_no_trap_then_flag) else $error("untrapped divide by zero not flagged");
  a_flags_sticky: assert property ($past(settled_q) && !$past(status_write_instr_in, 2)
    |-> ($past(flags) & ~flags) == 5'h00) else $error("flag cleared without write");
  a_write_image: assert property (status_write_instr_in && !op_valid_in |-> ##2
    (fp_status_word_out & 32'h001F1F1F) == ($past(status_write_data_in, 2) & 32'h001F1F1F))
    else $error("written fields not in word");
  a_ctrl_levels: assert property (settled_q |-> ctrl == fp_status_word_out[12:8])
    else $error("control outputs differ from word");
  a_busy_sync: assert property (op_valid_in && !status_write_instr_in |=> busy_out == $past(sync_operation_out))
    else $error("busy does not follow sync mode");
  a_qnan_untrapped: assert property (settled_q && arith && conds == 9'h040 && !fp_status_word_out[16]
    |=> quiet_nan_result_out && !trap_out) else $error("untrapped invalid without quiet result");
  a_read_answer: assert property (status_read_instr_in |=> status_read_valid_out)
    else $error("read not answered");
endmodule // fp_status_exception_unit_properties

bind fp_status_exception_unit fp_status_exception_unit_properties chk_u (.clk_in, .reset_in, .status_write_instr_in,
  .status_write_data_in, .status_read_instr_in, .op_valid_in, .op_class_in, .snan_operand_in, .nan_operand_in,
  .invalid_operand_in, .int_convert_fail_in, .div_zero_in, .overflow_in, .tiny_in, .accuracy_loss_in, .inexact_in,
  .fp_status_word_out, .status_read_valid_out, .trap_out, .trap_cause_out, .flush_denormals_out,
  .snan_convert_fault_out, .sync_operation_out, .expanded_decimal_out, .alt_carry_compare_out,
  .quiet_nan_result_out, .busy_out);
`default_nettype wire

// >>> verification/fp_status_exception_unit_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "fp_status_cfg.svh"
`define CHECK(g, e) begin checked++; if ((g) !== (e)) begin fails++; $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end

module fp_status_exception_unit_tb_top;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic status_write_instr_in, status_read_instr_in, status_read_valid_out, trap_out, quiet_nan_result_out, busy_out;
  logic flush_denormals_out, snan_convert_fault_out, sync_operation_out, expanded_decimal_out, alt_carry_compare_out;
  logic [31:0] status_write_data_in, fp_status_word_out, rd;
  logic [4:0] trap_cause_out;
  logic op_valid_in = 1'b0;
  logic [3:0] op_class_in = 4'h0;
  logic [1:0] src_prec_in = 2'h0, dst_prec_in = 2'h0;
  logic [8:0] cond_v = 9'h000;
  wire logic snan_operand_in, nan_operand_in, invalid_operand_in, int_convert_fail_in, div_zero_in;
  wire logic overflow_in, tiny_in, accuracy_loss_in, inexact_in;
  logic [6:0] seen;
  logic busy_seen;
  int fails = 0, checked = 0, cycles = 0;
  localparam logic [7:0] IDENT = `FPS_IDENTITY_VALUE | 8'h80;
  localparam logic [31:0] TRAPS = 32'h001F0000;
  assign {snan_operand_in, nan_operand_in, invalid_operand_in, int_convert_fail_in, div_zero_in, overflow_in,
    tiny_in, accuracy_loss_in, inexact_in} = cond_v;
  always #50 clk_in = ~clk_in;
  fp_status_exception_unit dut_u (.clk_in, .reset_in, .status_write_instr_in, .status_write_data_in,
    .status_read_instr_in, .op_valid_in, .op_class_in, .src_prec_in, .dst_prec_in, .snan_operand_in, .nan_operand_in,
    .invalid_operand_in, .int_convert_fail_in, .div_zero_in, .overflow_in, .tiny_in, .accuracy_loss_in, .inexact_in,
    .fp_status_word_out, .status_read_valid_out, .trap_out, .trap_cause_out, .flush_denormals_out,
    .snan_convert_fault_out, .sync_operation_out, .expanded_decimal_out, .alt_carry_compare_out,
    .quiet_nan_result_out, .busy_out);
  host_core_model host_u (.clk_in, .fp_status_word_in(fp_status_word_out), .status_read_valid_in(status_read_valid_out),
    .status_write_instr_out(status_write_instr_in), .status_write_data_out(status_write_data_in),
    .status_read_instr_out(status_read_instr_in));
  task automatic stop_test;
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // One operation; the pulses are captured in the cycle they stand.
  task automatic run_op(input logic [3:0] cls, input logic [8:0] c, input logic [3:0] prec);
    @(negedge clk_in);
    op_valid_in = 1'b1;
    op_class_in = cls;
    cond_v = c;
    {src_prec_in, dst_prec_in} = prec;
    @(negedge clk_in);
    seen = {trap_out, quiet_nan_result_out, trap_cause_out};
    busy_seen = busy_out;
    op_valid_in = 1'b0;
    op_class_in = ~cls;
    cond_v = ~c;
  endtask
  // Load the word, run one operation, then read back the flags.
  task automatic chk_op(input logic [31:0] w, input logic [3:0] cls, input logic [8:0] c, input logic [3:0] prec,
    input logic [6:0] exp_seen, input logic [4:0] exp_flags);
    host_u.write_word(w);
    run_op(cls, c, prec);
    host_u.read_word(rd);
    `CHECK(seen, exp_seen)
    `CHECK(rd[4:0], exp_flags)
  endtask
  // Hang guard.
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fails++;
      stop_test();
    end
  end
  initial
  begin
    repeat (12) @(posedge clk_in);
    @(negedge clk_in);
    reset_in = 1'b0;
    host_u.write_word(32'h00000000);
    host_u.read_word(rd);
    `CHECK(rd, {IDENT, 24'h000000})
    for (int i = 0; i < 5; i++)
    begin
      host_u.write_word(32'h00000100 << i);
      host_u.read_word(rd);
      `CHECK({alt_carry_compare_out, expanded_decimal_out, sync_operation_out, snan_convert_fault_out, flush_denormals_out}, 5'h01 << i)
      `CHECK(rd, {IDENT, 24'h000100 << i})
    end
    run_op(4'h0, 9'h000, 4'h0);
    `CHECK(busy_seen, 1'b0)
    host_u.write_word(32'h00000400);
    run_op(4'h0, 9'h000, 4'h0);
    `CHECK(busy_seen, 1'b1)
    chk_op(32'h0, 4'h0, 9'h010, 4'h0, 7'h00, 5'h02);
    chk_op(32'h0, 4'h0, 9'h040, 4'h0, 7'h20, 5'h01);
    chk_op(32'h0, 4'h0, 9'h004, 4'h0, 7'h00, 5'h00);
    chk_op(32'h0, 4'h0, 9'h006, 4'h0, 7'h00, 5'h18);
    chk_op(32'h0, 4'h0, 9'h008, 4'h0, 7'h00, 5'h14);
    chk_op(32'h0, 4'h0, 9'h001, 4'h0, 7'h00, 5'h10);
    chk_op(TRAPS, 4'h0, 9'h040, 4'h0, 7'h41, 5'h00);
    chk_op(TRAPS, 4'h0, 9'h010, 4'h0, 7'h42, 5'h00);
    chk_op(TRAPS, 4'h0, 9'h009, 4'h0, 7'h44, 5'h00);
    chk_op(TRAPS, 4'h0, 9'h004, 4'h0, 7'h48, 5'h00);
    chk_op(TRAPS, 4'h0, 9'h001, 4'h0, 7'h50, 5'h00);
    chk_op(32'h00020000, 4'h0, 9'h008, 4'h0, 7'h00, 5'h14);
    chk_op(32'h00040000, 4'h0, 9'h008, 4'h0, 7'h44, 5'h00);
    chk_op(32'h0, 4'h4, 9'h100, 4'h5, 7'h00, 5'h00);
    chk_op(32'h0, 4'h1, 9'h100, 4'h2, 7'h00, 5'h00);
    chk_op(32'h0, 4'h4, 9'h100, 4'h1, 7'h20, 5'h01);
    chk_op(32'h0, 4'h0, 9'h100, 4'h0, 7'h20, 5'h01);
    chk_op(32'h0, 4'h8, 9'h100, 4'h2, 7'h00, 5'h00);
    chk_op(32'h00000200, 4'h8, 9'h100, 4'h2, 7'h20, 5'h01);
    chk_op(32'h0, 4'h8, 9'h100, 4'h1, 7'h20, 5'h01);
    chk_op(32'h0, 4'h9, 9'h080, 4'h0, 7'h20, 5'h01);
    chk_op(32'h0, 4'hA, 9'h080, 4'h0, 7'h20, 5'h01);
    chk_op(32'h0, 4'hC, 9'h020, 4'h0, 7'h20, 5'h01);
    // A later clean operation must not clear a raised flag.
    host_u.write_word(32'h00000000);
    run_op(4'h0, 9'h010, 4'h0);
    run_op(4'h0, 9'h000, 4'h0);
    host_u.read_word(rd);
    `CHECK(rd[4:0], 5'h02)
    @(negedge clk_in);
    reset_in = 1'b1;
    @(negedge clk_in);
    reset_in = 1'b0;
    host_u.read_word(rd);
    `CHECK(rd, {IDENT, 24'h000002})
    stop_test();
  end
endmodule // fp_status_exception_unit_tb_top
`default_nettype wire

// >>> verification/host_core_model.sv
`timescale 1ns/10ps
`default_nettype none

// Host core: issues status transfers at the falling edge.
module host_core_model (
  input wire logic clk_in,
  input wire logic [31:0] fp_status_word_in,
  input wire logic status_read_valid_in,
  output logic status_write_instr_out,
  output logic [31:0] status_write_data_out,
  output logic status_read_instr_out
);
  initial
  begin
    status_write_instr_out = 1'b0;
    status_write_data_out = 32'h00000000;
    status_read_instr_out = 1'b0;
  end
  // Reserved bits go out as zero; the data lines show the inverse once released.
  task automatic write_word(input logic [31:0] data);
    @(negedge clk_in);
    status_write_instr_out = 1'b1;
    status_write_data_out = data & 32'h001F1F1F;
    @(negedge clk_in);
    status_write_instr_out = 1'b0;
    status_write_data_out = ~status_write_data_out;
  endtask
  // The answer stands for one cycle after the taking edge.
  task automatic read_word(output logic [31:0] data);
    @(negedge clk_in);
    status_read_instr_out = 1'b1;
    @(negedge clk_in);
    status_read_instr_out = 1'b0;
    data = status_read_valid_in ? fp_status_word_in : 32'hFFFFFFFF;
  endtask
endmodule // host_core_model
`default_nettype wire
